// file: cbc_ctrl.sv
// Purpose: status bus command controller top
// Assumes: 100 MHz core_clk_in; pins asynchronous; Avalon-MM slave for control
// Notes:   each machine cycle is T1 (strobe), T2 (read class), T3 (write)
//
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.

// How it works
// - status 000 ack, 001 io read, 010 io writes, 100/101/110 memory, 011/111 none
// - strap high selects io-bus mode; shared pin becomes peripheral enable
// - io-bus mode: io and ack commands ignore address enable
// - io-bus mode: io commands start at once, peripheral enable and direction follow
// - io-bus mode: memory commands still wait for address enable
// - system-bus mode: no command until fixed delay after address enable low
// - advanced writes start one phase before normal writes
// - acknowledge command times like an io read
// - data enable gates the transceiver, direction sets its way
// - io-bus mode: peripheral enable is the io transceiver enable
// - system-bus mode: cascade enable during acknowledge, never in io-bus mode
// - cascade enable rises with the address strobe of the acknowledge
// - address strobe pulses once every machine cycle, halt included
// - command enable low drives commands inactive, not three-stated
// - enable 110 to 250 ns after address enable low; release at once
// - direction high for writes, low for reads
// - command enable low forces data enables inactive too
// - passive status keeps commands high; commands low active
module cbc_ctrl
  import cbc_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [2:0]  cpu_status_in,
  input  wire logic        io_bus_strap_in,
  input  wire logic        addr_enable_n_in,
  input  wire logic        cmd_enable_in,
  output logic             mem_rd_cmd_n_out,
  output logic             mem_wr_cmd_n_out,
  output logic             adv_mem_wr_cmd_n_out,
  output logic             io_rd_cmd_n_out,
  output logic             io_wr_cmd_n_out,
  output logic             adv_io_wr_cmd_n_out,
  output logic             int_ack_cmd_n_out,
  output logic             mem_cmd_oe_out,
  output logic             io_cmd_oe_out,
  output logic             addr_latch_strobe_out,
  output logic             data_enable_out,
  output logic             data_dir_out,
  output logic             cascade_periph_out,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    cbc_phase_t             phase;
    cbc_kind_t              kind;
    logic                   ack_second;
    logic [GRANT_CNT_W-1:0] grant_cnt;
    logic                   grant_ok;
    logic                   mem_rd_n;
    logic                   mem_wr_n;
    logic                   adv_mem_wr_n;
    logic                   io_rd_n;
    logic                   io_wr_n;
    logic                   adv_io_wr_n;
    logic                   int_ack_n;
    logic                   mem_oe;
    logic                   io_oe;
    logic                   ale;
    logic                   dat_en;
    logic                   dir;
    logic                   casc_per;
    logic [1:0]             ctrl;
    logic [CYC_CNT_W-1:0]   cycles;
    logic                   waitreq;
    logic [31:0]            rdata;
  } cbc_state_t;

  cbc_state_t s;
  cbc_state_t next_s;

  logic [2:0] sts;
  logic       io_mode;
  logic       grant_n;
  logic       cmd_en;
  cbc_kind_t  dec_kind;
  logic       dec_active;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // reset values: passive status, system mode, bus not granted, disabled
  cbc_sync #(
    .W (6)
  ) u_sync (
    .core_clk_in  (core_clk_in),
    .rst_n_in     (rst_n_in),
    .async_in     ({cpu_status_in, io_bus_strap_in, addr_enable_n_in, cmd_enable_in}),
    .reset_val_in ({STS_PASSIVE, 1'b0, 1'b1, 1'b0}),
    .sync_out     ({sts, io_mode, grant_n, cmd_en})
  );

  cbc_decode u_decode (
    .status_in  (sts),
    .kind_out   (dec_kind),
    .active_out (dec_active)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic cmd_en_eff;
  logic mem_go;
  logic io_go;
  logic early;
  logic late;
  logic io_kind;
  logic mem_kind;
  logic req;

  always_comb begin
    next_s   = s;
    cmd_en_eff = cmd_en & s.ctrl[CTRL_SOFT_EN];
    early    = 1'b0;
    late     = 1'b0;
    io_kind  = 1'b0;
    mem_kind = 1'b0;
    mem_go   = 1'b0;
    io_go    = 1'b0;
    req      = avs_read_in | avs_write_in;

    // fixed delay after address enable low; high drops it at once
    if (grant_n) begin
      next_s.grant_cnt = '0;
      next_s.grant_ok  = 1'b0;
    end else if (s.grant_cnt != GRANT_CNT_W'(GRANT_DLY_CYC)) begin
      next_s.grant_cnt = s.grant_cnt + 1'b1;
      next_s.grant_ok  = 1'b0;
    end else begin
      next_s.grant_ok  = 1'b1;
    end

    // phase sequencing on core clock edges
    next_s.ale = 1'b0;
    case (s.phase)
      CBC_IDLE: begin
        if (dec_active) begin
          next_s.phase  = CBC_T1;
          next_s.kind   = dec_kind;
          next_s.ale    = 1'b1;
          next_s.cycles = s.cycles + 1'b1;
        end
      end
      CBC_T1: begin
        next_s.phase = CBC_T2;
      end
      CBC_T2: begin
        next_s.phase = CBC_T3;
      end
      CBC_T3: begin
        if (!dec_active) begin
          next_s.phase = CBC_IDLE;
          next_s.kind  = '0;
          // pair acknowledge cycles; any other cycle restarts the pairing
          next_s.ack_second = s.kind.ack ? ~s.ack_second : 1'b0;
        end
      end
      default: begin
        next_s.phase = CBC_IDLE;
        next_s.kind  = '0;
      end
    endcase

    early    = (next_s.phase == CBC_T2) || (next_s.phase == CBC_T3);
    late     = (next_s.phase == CBC_T3);
    io_kind  = next_s.kind.io_rd | next_s.kind.io_wr | next_s.kind.ack;
    mem_kind = next_s.kind.mem_rd | next_s.kind.mem_wr;

    // three-state enables follow address enable; io enable also held on in io-bus mode
    next_s.mem_oe = next_s.grant_ok;
    next_s.io_oe  = io_mode | next_s.grant_ok;
    mem_go = next_s.grant_ok & cmd_en_eff;
    io_go  = next_s.io_oe & cmd_en_eff;

    // commands: read class and advanced writes early, normal writes late
    next_s.mem_rd_n     = ~(early & next_s.kind.mem_rd & mem_go);
    next_s.adv_mem_wr_n = ~(early & next_s.kind.mem_wr & mem_go);
    next_s.mem_wr_n     = ~(late  & next_s.kind.mem_wr & mem_go);
    next_s.io_rd_n      = ~(early & next_s.kind.io_rd  & io_go);
    next_s.adv_io_wr_n  = ~(early & next_s.kind.io_wr  & io_go);
    next_s.io_wr_n      = ~(late  & next_s.kind.io_wr  & io_go);
    next_s.int_ack_n    = ~(early & next_s.kind.ack    & io_go);

    // direction high only for writes, set from the strobe phase on
    next_s.dir = (next_s.phase != CBC_IDLE) &
                 (next_s.kind.mem_wr | next_s.kind.io_wr);

    if (io_mode) begin
      // io transfers use the peripheral transceiver
      next_s.dat_en   = early & mem_kind & mem_go;
      next_s.casc_per = ~(early & io_kind & cmd_en_eff);
    end else begin
      next_s.dat_en   = early & (mem_kind | io_kind) & mem_go;
      // cascade rides with the strobe; first of a pair may be masked
      next_s.casc_per = (next_s.phase == CBC_T1) & next_s.kind.ack &
                        (next_s.ack_second | ~s.ctrl[CTRL_MASK_1ST]);
    end

    // register bus: answer one cycle after the request is seen
    next_s.waitreq = ~(req & s.waitreq);
    if (avs_read_in & s.waitreq) begin
      case (avs_address_in)
        REG_CTRL:   next_s.rdata = {30'h0, s.ctrl};
        REG_STATUS: next_s.rdata = {16'h0, 4'h0, s.phase, s.grant_ok, cmd_en,
                                    io_mode, s.ack_second, 1'b0, sts};
        REG_CYCLES: next_s.rdata = {16'h0, s.cycles};
        default:    next_s.rdata = '0;
      endcase
    end
    // a write lands only at the edge where the master sees waitrequest low
    if (avs_write_in && !s.waitreq && avs_address_in == REG_CTRL &&
        avs_byteenable_in[0]) begin
      next_s.ctrl = avs_writedata_in[1:0];
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      s              <= '0;
      s.phase        <= CBC_IDLE;
      s.mem_rd_n     <= 1'b1;
      s.mem_wr_n     <= 1'b1;
      s.adv_mem_wr_n <= 1'b1;
      s.io_rd_n      <= 1'b1;
      s.io_wr_n      <= 1'b1;
      s.adv_io_wr_n  <= 1'b1;
      s.int_ack_n    <= 1'b1;
      s.ctrl         <= CTRL_RESET;
      s.waitreq      <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  assign mem_rd_cmd_n_out      = s.mem_rd_n;
  assign mem_wr_cmd_n_out      = s.mem_wr_n;
  assign adv_mem_wr_cmd_n_out  = s.adv_mem_wr_n;
  assign io_rd_cmd_n_out       = s.io_rd_n;
  assign io_wr_cmd_n_out       = s.io_wr_n;
  assign adv_io_wr_cmd_n_out   = s.adv_io_wr_n;
  assign int_ack_cmd_n_out     = s.int_ack_n;
  assign mem_cmd_oe_out        = s.mem_oe;
  assign io_cmd_oe_out         = s.io_oe;
  assign addr_latch_strobe_out = s.ale;
  assign data_enable_out       = s.dat_en;
  assign data_dir_out          = s.dir;
  assign cascade_periph_out    = s.casc_per;
  assign avs_readdata_out      = s.rdata;
  assign avs_waitrequest_out   = s.waitreq;

endmodule

// file: cbc_pkg.sv
// Purpose: constants and types shared by the status bus command controller
// Assumes: 100 MHz core clock
// Notes:   offsets are byte addresses on the register bus
package cbc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int GRANT_MIN_NS   = 110;
  localparam int GRANT_MAX_NS   = 250;
  // least time rounds up to whole cycles
  localparam int GRANT_DLY_CYC  = (GRANT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GRANT_CNT_W    = $clog2(GRANT_DLY_CYC + 1);

  // ----------------------------------------------------------------
  // status codes (bit2, bit1, bit0)
  // ----------------------------------------------------------------
  localparam logic [2:0] STS_INT_ACK = 3'h0;
  localparam logic [2:0] STS_IO_RD   = 3'h1;
  localparam logic [2:0] STS_IO_WR   = 3'h2;
  localparam logic [2:0] STS_HALT    = 3'h3;
  localparam logic [2:0] STS_CODE_RD = 3'h4;
  localparam logic [2:0] STS_MEM_RD  = 3'h5;
  localparam logic [2:0] STS_MEM_WR  = 3'h6;
  localparam logic [2:0] STS_PASSIVE = 3'h7;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  REG_CTRL       = 4'h0;
  localparam logic [3:0]  REG_STATUS     = 4'h4;
  localparam logic [3:0]  REG_CYCLES     = 4'h8;
  localparam int          CTRL_SOFT_EN   = 0;
  localparam int          CTRL_MASK_1ST  = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h1;
  localparam int          CYC_CNT_W      = 16;

  // ----------------------------------------------------------------
  // machine cycle phases
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CBC_IDLE = 4'b0001,
    CBC_T1   = 4'b0010,
    CBC_T2   = 4'b0100,
    CBC_T3   = 4'b1000
  } cbc_phase_t;

  typedef struct packed {
    logic ack;
    logic io_rd;
    logic io_wr;
    logic mem_rd;
    logic mem_wr;
  } cbc_kind_t;

endpackage

// file: cbc_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes:   first stage is read only by the second stage
module cbc_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] reset_val_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cbc_sync_t;

  cbc_sync_t s;
  cbc_sync_t next_s;

  always_comb begin
    next_s.s1 = async_in;
    next_s.s2 = s.s1;
  end

  // reset value is a constant tie-off at the instance
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      s <= {reset_val_in, reset_val_in};
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.s2;

endmodule

// file: cbc_decode.sv
// Purpose: status code to cycle kind decode
// Assumes: status already synchronised
// Notes:   halt and passive decode to no kind
module cbc_decode
  import cbc_pkg::*;
(
  input  wire logic [2:0] status_in,
  output cbc_kind_t       kind_out,
  output logic            active_out
);

  always_comb begin
    kind_out        = '0;
    active_out      = (status_in != STS_PASSIVE);
    case (status_in)
      STS_INT_ACK: kind_out.ack    = 1'b1;
      STS_IO_RD:   kind_out.io_rd  = 1'b1;
      STS_IO_WR:   kind_out.io_wr  = 1'b1;
      STS_CODE_RD: kind_out.mem_rd = 1'b1;
      STS_MEM_RD:  kind_out.mem_rd = 1'b1;
      STS_MEM_WR:  kind_out.mem_wr = 1'b1;
      default:     kind_out        = '0;    // halt, passive
    endcase
  end

endmodule

// file: cbc_ctrl_asserts.sv
// Purpose: port-level checks for the status bus command controller
// Assumes: one clock domain, synchronous active-low reset
// Notes:   pins pass two sync stages, so windows allow a few edges
module cbc_ctrl_chk
  import cbc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic io_bus_strap_in,
  input wire logic addr_enable_n_in,
  input wire logic cmd_enable_in,
  input wire logic mem_rd_cmd_n_out,
  input wire logic mem_wr_cmd_n_out,
  input wire logic adv_mem_wr_cmd_n_out,
  input wire logic io_rd_cmd_n_out,
  input wire logic io_wr_cmd_n_out,
  input wire logic adv_io_wr_cmd_n_out,
  input wire logic int_ack_cmd_n_out,
  input wire logic mem_cmd_oe_out,
  input wire logic io_cmd_oe_out,
  input wire logic addr_latch_strobe_out,
  input wire logic data_enable_out,
  input wire logic data_dir_out,
  input wire logic cascade_periph_out
);
  logic [3:0] grant_cnt;

  // saturates: only the lower bound matters
  always_ff @(posedge core_clk_in)
    if (!rst_n_in || addr_enable_n_in) grant_cnt <= 4'h0;
    else if (grant_cnt != 4'hf) grant_cnt <= grant_cnt + 4'h1;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  strobe_pulse_a: assert property (
    addr_latch_strobe_out |=> !addr_latch_strobe_out) else $error("strobe too long");
  cmd_onehot_a: assert property (
    $onehot0(~{mem_rd_cmd_n_out, mem_wr_cmd_n_out, io_rd_cmd_n_out, io_wr_cmd_n_out,
               int_ack_cmd_n_out})) else $error("two command kinds at once");
  cmd_gate_a: assert property (
    (!cmd_enable_in) [*4] |-> (&{mem_rd_cmd_n_out, mem_wr_cmd_n_out, adv_mem_wr_cmd_n_out,
      io_rd_cmd_n_out, io_wr_cmd_n_out, adv_io_wr_cmd_n_out, int_ack_cmd_n_out})
      && !data_enable_out) else $error("command while disabled");
  adv_mem_a: assert property (
    $fell(mem_wr_cmd_n_out) |-> !$past(adv_mem_wr_cmd_n_out)) else $error("late adv mem");
  adv_io_a: assert property (
    $fell(io_wr_cmd_n_out) |-> !$past(adv_io_wr_cmd_n_out)) else $error("late adv io");
  dir_write_a: assert property (
    (!mem_wr_cmd_n_out || !io_wr_cmd_n_out) |-> data_dir_out) else $error("dir low on write");
  dir_read_a: assert property (
    (!mem_rd_cmd_n_out || !io_rd_cmd_n_out) |-> !data_dir_out) else $error("dir high on read");
  grant_wait_a: assert property (
    $fell(mem_rd_cmd_n_out) |-> grant_cnt >= GRANT_DLY_CYC) else $error("memory read too early");
  grant_release_a: assert property (
    addr_enable_n_in [*4] |-> !mem_cmd_oe_out) else $error("drivers on without grant");
  io_always_a: assert property (
    io_bus_strap_in [*4] |-> io_cmd_oe_out) else $error("io drivers off in io mode");
  io_prompt_a: assert property (
    (io_bus_strap_in && cmd_enable_in) [*4] ##0
      ($fell(io_rd_cmd_n_out) || $fell(int_ack_cmd_n_out)) |-> $past(addr_latch_strobe_out))
    else $error("io command not after strobe");
  cascade_strobe_a: assert property (
    (!io_bus_strap_in) [*4] ##0 $rose(cascade_periph_out) |-> addr_latch_strobe_out)
    else $error("cascade without strobe");
endmodule

bind cbc_ctrl cbc_ctrl_chk cbc_ctrl_chk_inst (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .io_bus_strap_in(io_bus_strap_in),
  .addr_enable_n_in(addr_enable_n_in), .cmd_enable_in(cmd_enable_in),
  .mem_rd_cmd_n_out(mem_rd_cmd_n_out), .mem_wr_cmd_n_out(mem_wr_cmd_n_out),
  .adv_mem_wr_cmd_n_out(adv_mem_wr_cmd_n_out), .io_rd_cmd_n_out(io_rd_cmd_n_out),
  .io_wr_cmd_n_out(io_wr_cmd_n_out), .adv_io_wr_cmd_n_out(adv_io_wr_cmd_n_out),
  .int_ack_cmd_n_out(int_ack_cmd_n_out), .mem_cmd_oe_out(mem_cmd_oe_out),
  .io_cmd_oe_out(io_cmd_oe_out), .addr_latch_strobe_out(addr_latch_strobe_out),
  .data_enable_out(data_enable_out), .data_dir_out(data_dir_out),
  .cascade_periph_out(cascade_periph_out));

// file: cbc_cpu_model.sv
// Purpose: processor status source and bus arbiter grant
// Assumes: changes only just after a rising edge
// Notes:   status always returns to passive between cycles
module cbc_cpu_model (
  input  wire logic       core_clk_in,
  output logic      [2:0] cpu_status_out,
  output logic            addr_enable_n_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cpu_status_out = 3'h7;
    addr_enable_n_out = 1'b1;
  end

  task automatic run(input logic [2:0] code, input int hold);
    @(posedge core_clk_in);
    cpu_status_out <= code;
    repeat (hold) @(posedge core_clk_in);
    cpu_status_out <= 3'h7;
    repeat (4) @(posedge core_clk_in);
  endtask

  // grant only when the shared bus is free
  task automatic grant(input logic free);
    @(posedge core_clk_in);
    addr_enable_n_out <= !free;
  endtask
endmodule

// file: tb_cbc_ctrl.sv
// Purpose: self-checking bench for the command controller
// Assumes: 100 MHz clock, reset held 10 cycles
// Notes:   outputs sampled on the falling edge
module tb_cbc_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import cbc_pkg::*;

  logic        core_clk_in, rst_n_in, io_bus_strap_in, cmd_enable_in, addr_enable_n_in;
  logic [2:0]  cpu_status_in;
  logic        mem_rd_cmd_n_out, mem_wr_cmd_n_out, adv_mem_wr_cmd_n_out, io_rd_cmd_n_out;
  logic        io_wr_cmd_n_out, adv_io_wr_cmd_n_out, int_ack_cmd_n_out, mem_cmd_oe_out;
  logic        io_cmd_oe_out, addr_latch_strobe_out, data_enable_out, data_dir_out;
  logic        cascade_periph_out, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [3:0]  avs_address_in, avs_byteenable_in;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  int          errors, tests_run, ns, nc;
  logic [6:0]  acc;
  logic        dir, dat_en, pd;
  wire  [6:0]  cmds = {mem_rd_cmd_n_out, mem_wr_cmd_n_out, adv_mem_wr_cmd_n_out,
                       io_rd_cmd_n_out, io_wr_cmd_n_out, adv_io_wr_cmd_n_out, int_ack_cmd_n_out};

  cbc_ctrl cbc_ctrl_inst (.core_clk_in, .rst_n_in, .cpu_status_in, .io_bus_strap_in,
    .addr_enable_n_in, .cmd_enable_in, .mem_rd_cmd_n_out, .mem_wr_cmd_n_out,
    .adv_mem_wr_cmd_n_out, .io_rd_cmd_n_out, .io_wr_cmd_n_out, .adv_io_wr_cmd_n_out,
    .int_ack_cmd_n_out, .mem_cmd_oe_out, .io_cmd_oe_out, .addr_latch_strobe_out,
    .data_enable_out, .data_dir_out, .cascade_periph_out, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
    .avs_waitrequest_out);
  cbc_cpu_model cbc_cpu_model_inst (.core_clk_in, .cpu_status_out(cpu_status_in),
    .addr_enable_n_out(addr_enable_n_in));

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    chk(n < 20, 1'b1);
  endtask

  // one machine cycle, gathering what the outputs did
  task automatic cyc(input logic [2:0] code, input int hold);
    acc = 7'h7f;
    ns = 0;
    nc = 0;
    {dir, dat_en, pd} = 3'b001;
    fork
      cbc_cpu_model_inst.run(code, hold);
      repeat (hold + 5) @(negedge core_clk_in) begin
        acc &= cmds;
        ns += int'(addr_latch_strobe_out);
        nc += int'(cascade_periph_out);
        dir |= data_dir_out;
        dat_en |= data_enable_out;
        pd &= cascade_periph_out;
      end
    join
  endtask

  function automatic logic [6:0] exp_cmds(input logic [2:0] c);
    case (c)
      3'h0: return 7'h7e;
      3'h1: return 7'h77;
      3'h2: return 7'h79;
      3'h4, 3'h5: return 7'h3f;
      3'h6: return 7'h4f;
      default: return 7'h7f;
    endcase
  endfunction

  task automatic t_reset;
    logic [31:0] q;
    chk(cmds, 7'h7f);
    bus(1'b0, REG_CTRL, 32'h0, q);
    chk(q, {30'h0, CTRL_RESET});
    bus(1'b1, 4'hc, 32'hffffffff, q);
    bus(1'b0, 4'hc, 32'h0, q);
    chk(q, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_decode;
    logic [31:0] q0, q1;
    cbc_cpu_model_inst.grant(1'b1);
    repeat (20) @(posedge core_clk_in);
    bus(1'b0, REG_CYCLES, 32'h0, q0);
    for (int c = 0; c < 8; c++) begin
      cyc(c[2:0], 6);
      chk(acc, exp_cmds(c[2:0]));
      chk(ns, c != 7);
      chk(dir, c == 2 || c == 6);
      chk(dat_en, c != 3 && c != 7);
    end
    bus(1'b0, REG_CYCLES, 32'h0, q1);
    chk(16'(q1[15:0] - q0[15:0]), 16'h7);
    $display("test decode done");
  endtask

  // two back-to-back acknowledges per interrupt, mask off then on
  task automatic t_ack;
    logic [31:0] q;
    int          n1;
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, REG_CTRL, 32'h1 | (m << 1), q);
      cyc(3'h0, 6);
      n1 = nc;
      cyc(3'h0, 6);
      chk(n1, m == 0);
      chk(nc, 1);
      chk(acc[0], 1'b0);
    end
    bus(1'b1, REG_CTRL, 32'h1, q);
    $display("test ack done");
  endtask

  task automatic t_cmd_en;
    @(posedge core_clk_in);
    cmd_enable_in <= 1'b0;
    cyc(3'h6, 6);
    chk({acc, dat_en}, {7'h7f, 1'b0});
    @(posedge core_clk_in);
    cmd_enable_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    $display("test enable done");
  endtask

  task automatic t_io;
    logic [31:0] q;
    @(posedge core_clk_in);
    io_bus_strap_in <= 1'b1;
    cbc_cpu_model_inst.grant(1'b0);
    repeat (6) @(posedge core_clk_in);
    chk(io_cmd_oe_out, 1'b1);
    bus(1'b0, REG_STATUS, 32'h0, q);
    chk(q[5], 1'b1);
    cyc(3'h1, 6);
    chk({acc, pd}, {7'h77, 1'b0});
    cyc(3'h5, 6);
    chk(acc, 7'h7f);
    @(posedge core_clk_in);
    io_bus_strap_in <= 1'b0;
    repeat (6) @(posedge core_clk_in);
    $display("test io mode done");
  endtask

  task automatic t_grant;
    int n;
    n = 0;
    fork
      cbc_cpu_model_inst.run(3'h5, 40);
      begin
        repeat (3) @(posedge core_clk_in);
        cbc_cpu_model_inst.grant(1'b1);
        while (mem_rd_cmd_n_out !== 1'b0 && n < 40) begin
          @(negedge core_clk_in);
          n++;
        end
        chk(n >= GRANT_DLY_CYC && n <= GRANT_MAX_NS / CLK_PERIOD_NS, 1'b1);
        cbc_cpu_model_inst.grant(1'b0);
        repeat (4) @(negedge core_clk_in);
        chk({mem_cmd_oe_out, io_cmd_oe_out}, 2'b00);
      end
    join
    $display("test grant delay done");
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge core_clk_in);
    errors++;
    finish_test();
  end

  initial begin
    {errors, tests_run} = '0;
    {rst_n_in, io_bus_strap_in, cmd_enable_in, avs_read_in, avs_write_in} = 5'b00100;
    {avs_address_in, avs_byteenable_in, avs_writedata_in} = {8'h0f, 32'h0};
    repeat (10) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(negedge core_clk_in);
    t_reset();
    t_decode();
    t_ack();
    t_cmd_en();
    t_io();
    t_grant();
    finish_test();
  end
endmodule
